//--- srs_defs.svh
// Constants for the receiver status register bank
// Operation
// - Upper seven bits of the 15-bit rate ratio read back as a register field.
// - Lower eight bits of the rate ratio read back at offset 0x13.
// - C burst preamble shows at 0x14/0x15 while nonaudio is detected, else zero.
// - D burst preamble shows at 0x16/0x17 while nonaudio is detected, else zero.
// - In per-subframe nonaudio mode 0x16/0x17 carry channel B C preamble.
// - Fault byte at 0x18: validity, emphasis, nonaudio, preamble, CRC, absent, coding, lock.
// - Validity bit follows the validity flag of received subframes.
// - Emphasis bit follows pre-emphasis; after a read, interrupt again only on change.
// - Nonaudio bit follows status bit 1; re-interrupt only on audio return or type change.
// - Preamble-detect bit follows burst detection; re-interrupt only on change.
// - Checksum fault latches until the fault byte is read.
// - Input-absent bit follows stream absence; re-interrupt only on change.
// - Coding or parity fault latches and clears only on a read.
// - Lock bit follows PLL lock; re-interrupt only on change.
// - A mask bit at 1 lets its flag interrupt, at 0 suppresses it.
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH

// Register offsets on the control port
`define SRS_REG_RATIO_HI 7'h12
`define SRS_REG_RATIO_LO 7'h13
`define SRS_REG_PRE_C_HI 7'h14
`define SRS_REG_PRE_C_LO 7'h15
`define SRS_REG_PRE_D_HI 7'h16
`define SRS_REG_PRE_D_LO 7'h17
`define SRS_REG_FAULT 7'h18
`define SRS_REG_MASK 7'h19

// Control port device address, value arbitrary
`define SRS_DEV_ADDR 7'h2a

// Field layout and reset values
`define SRS_RATIO_W 15
`define SRS_RATIO_HI_MSB 14
`define SRS_RATIO_HI_LSB 8
`define SRS_RATIO_LO_MSB 7
`define SRS_BYTE_HI_MSB 15
`define SRS_BYTE_HI_LSB 8
`define SRS_BYTE_LO_MSB 7
`define SRS_MASK_RESET 8'h00
`define SRS_LATCH_BITS 8'h0a
`define SRS_BYTE_BITS 4'h8
`define SRS_FLAG_COUNT 8

`endif

//--- srs_pkg.sv
// Types shared by the receiver status register bank
package srs_pkg;

   // Receiver status; field order equals bit order of the fault byte
   typedef struct packed {
      logic received_validity_flag;
      logic emphasis;
      logic nonaudio;
      logic burst_nonaudio;
      logic status_checksum_fault;
      logic input_absent_flag;
      logic coding_fault;
      logic pll_lock;
   } srs_rx_status_t;

   // Burst preamble capture from the receiver
   typedef struct packed {
      logic strobe;
      logic subframe_mode;
      logic [15:0] pc;
      logic [15:0] pd;
      logic [15:0] pc_b;
   } srs_burst_t;

   typedef enum logic [2:0] {
      SRS_IDLE,
      SRS_RX,
      SRS_ACK,
      SRS_TX,
      SRS_TXACK
   } srs_port_state_t;

   typedef enum logic [1:0] {
      SRS_PH_DEV,
      SRS_PH_REG,
      SRS_PH_DATA
   } srs_phase_t;

endpackage

//--- srs_flag_cell.sv
// One bit of the fault byte with its interrupt pending state
`timescale 1ns/1ps
module srs_flag_cell #(
   parameter bit LATCH = 1'b0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Source: level, or error pulse when latching
   input wire logic src_i,
   input wire logic retrig_i,
   // Read tracking
   input wire logic snap_i,
   input wire logic done_i,
   // Results
   output logic value_o,
   output logic pend_o
);

   logic val_q, val_d;
   logic pend_q, pend_d;
   logic seen_q, seen_d;
   logic ev;
   logic clr;

   // Event detect and clear; an event always wins over the clear
   always_comb begin
      if (LATCH) begin
         ev = src_i;
      end else begin
         ev = (src_i != val_q) | retrig_i;
      end
      clr = done_i & seen_q & ~ev;
      if (LATCH) begin
         val_d = ev | (val_q & ~clr);
      end else begin
         val_d = src_i;
      end
      pend_d = ev | (pend_q & ~clr);
      // Seen marks that the host already got this state in a snapshot
      seen_d = (snap_i & ~ev) | (seen_q & ~ev & ~done_i);
   end

   // State registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         val_q <= 1'b0;
         pend_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         val_q <= val_d;
         pend_q <= pend_d;
         seen_q <= seen_d;
      end
   end

   assign value_o = val_q;
   assign pend_o = pend_q;

endmodule

//--- srs_status_regs.sv
// Receiver status register bank behind an I2C-compatible control port
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_status_regs (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Control port pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Receiver and converter status
   input srs_pkg::srs_rx_status_t rx_status_i,
   input srs_pkg::srs_burst_t burst_i,
   input wire logic [`SRS_RATIO_W-1:0] rate_ratio_value_i,
   // Interrupt request
   output logic irq_o
);

   localparam logic [`SRS_FLAG_COUNT-1:0] LatchBits = `SRS_LATCH_BITS;

   // Status holding registers
   logic [`SRS_RATIO_W-1:0] ratio_q, ratio_d;
   logic [7:0] ratio_lo_hold_q, ratio_lo_hold_d;
   logic [15:0] pre_c_q, pre_c_d;
   logic [15:0] pre_d_q, pre_d_d;
   logic [7:0] mask_q, mask_d;
   logic irq_q, irq_d;

   // Control port state
   srs_pkg::srs_port_state_t st_q, st_d;
   srs_pkg::srs_phase_t phase_q, phase_d;
   logic scl_q, sda_q;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [6:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic mack_q, mack_d;
   logic oe_n_q, oe_n_d;
   logic flags_rd_q, flags_rd_d;

   // Per-cycle strobes
   logic scl_rise, scl_fall, start_seen, stop_seen;
   logic load, wr_en, snap, done;
   logic [7:0] rdata;
   logic [`SRS_FLAG_COUNT-1:0] flag_src, flag_retrig, flag_val, flag_pend;

   // Bus line edges; pins are synchronous to clk_i so no synchroniser
   assign scl_rise = scl_i & ~scl_q;
   assign scl_fall = ~scl_i & scl_q;
   assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;

   // Read data for the current pointer; unmapped offsets read zero
   always_comb begin
      case (ptr_q)
         `SRS_REG_RATIO_HI: rdata = {1'b0, ratio_q[`SRS_RATIO_HI_MSB:`SRS_RATIO_HI_LSB]};
         `SRS_REG_RATIO_LO: rdata = ratio_lo_hold_q;
         `SRS_REG_PRE_C_HI: rdata = pre_c_q[`SRS_BYTE_HI_MSB:`SRS_BYTE_HI_LSB];
         `SRS_REG_PRE_C_LO: rdata = pre_c_q[`SRS_BYTE_LO_MSB:0];
         `SRS_REG_PRE_D_HI: rdata = pre_d_q[`SRS_BYTE_HI_MSB:`SRS_BYTE_HI_LSB];
         `SRS_REG_PRE_D_LO: rdata = pre_d_q[`SRS_BYTE_LO_MSB:0];
         `SRS_REG_FAULT: rdata = flag_val;
         `SRS_REG_MASK: rdata = mask_q;
         default: rdata = 8'h00;
      endcase
   end

   // Control port sequencer: address, register pointer, then data bytes
   always_comb begin
      st_d = st_q;
      phase_d = phase_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      mack_d = mack_q;
      oe_n_d = oe_n_q;
      flags_rd_d = flags_rd_q;
      load = 1'b0;
      wr_en = 1'b0;
      done = 1'b0;
      if (start_seen) begin
         // Start or repeated start always restarts address reception
         st_d = srs_pkg::SRS_RX;
         phase_d = srs_pkg::SRS_PH_DEV;
         cnt_d = 4'h0;
         oe_n_d = 1'b1;
      end else if (stop_seen) begin
         st_d = srs_pkg::SRS_IDLE;
         oe_n_d = 1'b1;
      end else begin
         case (st_q)
            srs_pkg::SRS_IDLE: begin
               oe_n_d = 1'b1;
            end
            srs_pkg::SRS_RX: begin
               if (scl_rise && cnt_q != `SRS_BYTE_BITS) begin
                  sh_d = {sh_q[6:0], sda_i};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == `SRS_BYTE_BITS) begin
                  st_d = srs_pkg::SRS_ACK;
                  oe_n_d = 1'b0;
                  case (phase_q)
                     srs_pkg::SRS_PH_DEV: begin
                        rw_d = sh_q[0];
                        if (sh_q[7:1] != `SRS_DEV_ADDR) begin
                           // Not our address: stay off the bus until next start
                           st_d = srs_pkg::SRS_IDLE;
                           oe_n_d = 1'b1;
                        end
                     end
                     srs_pkg::SRS_PH_REG: begin
                        ptr_d = sh_q[6:0];
                     end
                     default: begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 7'h01;
                     end
                  endcase
               end
            end
            srs_pkg::SRS_ACK: begin
               if (scl_fall) begin
                  cnt_d = 4'h0;
                  if (phase_q == srs_pkg::SRS_PH_DEV && rw_q) begin
                     load = 1'b1;
                     st_d = srs_pkg::SRS_TX;
                  end else begin
                     oe_n_d = 1'b1;
                     st_d = srs_pkg::SRS_RX;
                     if (phase_q == srs_pkg::SRS_PH_DEV) begin
                        phase_d = srs_pkg::SRS_PH_REG;
                     end else begin
                        phase_d = srs_pkg::SRS_PH_DATA;
                     end
                  end
               end
            end
            srs_pkg::SRS_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == `SRS_BYTE_BITS) begin
                     // Byte fully shifted out: the read counts as complete here
                     oe_n_d = 1'b1;
                     st_d = srs_pkg::SRS_TXACK;
                     done = flags_rd_q;
                     flags_rd_d = 1'b0;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_n_d = sh_q[6];
                  end
               end
            end
            srs_pkg::SRS_TXACK: begin
               if (scl_rise) begin
                  mack_d = ~sda_i;
                  cnt_d = 4'h0;
               end else if (scl_fall) begin
                  if (mack_q) begin
                     load = 1'b1;
                     st_d = srs_pkg::SRS_TX;
                  end else begin
                     st_d = srs_pkg::SRS_IDLE;
                  end
               end
            end
            default: begin
               st_d = srs_pkg::SRS_IDLE;
               oe_n_d = 1'b1;
            end
         endcase
      end
      // Loading a byte drives its top bit and moves the pointer on
      if (load) begin
         sh_d = rdata;
         oe_n_d = rdata[7];
         ptr_d = ptr_q + 7'h01;
         flags_rd_d = (ptr_q == `SRS_REG_FAULT);
      end
   end

   // Snapshot of the fault byte happens as it is loaded for shifting
   assign snap = load & (ptr_q == `SRS_REG_FAULT);

   // Control port registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_q <= srs_pkg::SRS_IDLE;
         phase_q <= srs_pkg::SRS_PH_DEV;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 7'h00;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         oe_n_q <= 1'b1;
         flags_rd_q <= 1'b0;
      end else begin
         st_q <= st_d;
         phase_q <= phase_d;
         scl_q <= scl_i;
         sda_q <= sda_i;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         mack_q <= mack_d;
         oe_n_q <= oe_n_d;
         flags_rd_q <= flags_rd_d;
      end
   end

   // Status capture, mask write and interrupt gating
   always_comb begin
      ratio_d = rate_ratio_value_i;
      ratio_lo_hold_d = ratio_lo_hold_q;
      // Reading the high byte freezes the low byte so the pair is coherent
      if (load && ptr_q == `SRS_REG_RATIO_HI) begin
         ratio_lo_hold_d = ratio_q[`SRS_RATIO_LO_MSB:0];
      end else if (!(st_q == srs_pkg::SRS_TX || st_q == srs_pkg::SRS_TXACK)) begin
         ratio_lo_hold_d = ratio_q[`SRS_RATIO_LO_MSB:0];
      end
      pre_c_d = pre_c_q;
      pre_d_d = pre_d_q;
      if (!rx_status_i.burst_nonaudio) begin
         pre_c_d = 16'h0000;
         pre_d_d = 16'h0000;
      end else if (burst_i.strobe) begin
         pre_c_d = burst_i.pc;
         if (burst_i.subframe_mode) begin
            pre_d_d = burst_i.pc_b;
         end else begin
            pre_d_d = burst_i.pd;
         end
      end
      mask_d = mask_q;
      if (wr_en && ptr_q == `SRS_REG_MASK) begin
         mask_d = sh_q;
      end
      irq_d = |(flag_pend & mask_q);
   end

   // Status registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ratio_q <= '0;
         ratio_lo_hold_q <= 8'h00;
         pre_c_q <= 16'h0000;
         pre_d_q <= 16'h0000;
         mask_q <= `SRS_MASK_RESET;
         irq_q <= 1'b0;
      end else begin
         ratio_q <= ratio_d;
         ratio_lo_hold_q <= ratio_lo_hold_d;
         pre_c_q <= pre_c_d;
         pre_d_q <= pre_d_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   // Flag sources; a new burst type while nonaudio re-arms that bit
   always_comb begin
      flag_src = rx_status_i;
      flag_retrig = 8'h00;
      flag_retrig[5] = rx_status_i.nonaudio & burst_i.strobe & (burst_i.pc != pre_c_q);
   end

   // One cell per fault bit; latching kinds hold errors until read
   for (genvar i = 0; i < `SRS_FLAG_COUNT; i++) begin : g_flag
      srs_flag_cell #(
         .LATCH(LatchBits[i])
      ) u_cell (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .src_i(flag_src[i]),
         .retrig_i(flag_retrig[i]),
         .snap_i(snap),
         .done_i(done),
         .value_o(flag_val[i]),
         .pend_o(flag_pend[i])
      );
   end

   // Open-drain data line only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = oe_n_q;
   assign irq_o = irq_q;

endmodule

//--- srs_status_regs_monitor.sv
// Port checker for the receiver status register bank
`timescale 1ns/1ps
module srs_status_regs_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Control port
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   // Status and interrupt
   input srs_pkg::srs_rx_status_t rx_status_i,
   input srs_pkg::srs_burst_t burst_i,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   srs_pkg::srs_rx_status_t rx_q;
   logic scl_q;
   logic [2:0] in_quiet_q;
   logic [2:0] bus_quiet_q;
   // Saturating age of the last status event and bus clock edge
   always_ff @(posedge clk_i) begin
      rx_q <= rx_status_i;
      scl_q <= scl_i;
      if (reset_i || rx_status_i != rx_q || burst_i.strobe) begin
         in_quiet_q <= 3'h0;
      end else if (in_quiet_q != 3'h7) begin
         in_quiet_q <= in_quiet_q + 3'h1;
      end
      if (reset_i || scl_i != scl_q) begin
         bus_quiet_q <= 3'h0;
      end else if (bus_quiet_q != 3'h7) begin
         bus_quiet_q <= bus_quiet_q + 3'h1;
      end
   end
   sequence start_s;
      scl_i && $past(scl_i) && $fell(sda_i);
   endsequence
   sequence stop_s;
      scl_i && $past(scl_i) && $rose(sda_i);
   endsequence
   sda_zero_a: assert property (sda_o == 1'b0)
      else $error("data output not low");
   reset_idle_a: assert property (disable iff (1'b0) reset_i |=> sda_oe_n_o && !irq_o)
      else $error("outputs active after reset");
   hold_high_a: assert property (scl_i && $past(scl_i) && !$past(reset_i) |-> $stable(sda_oe_n_o))
      else $error("data changed while clock high");
   edge_low_a: assert property ($changed(sda_oe_n_o) && !$past(reset_i) |-> !$past(scl_i))
      else $error("drive changed outside clock low");
   irq_cause_a: assert property ($rose(irq_o) |-> in_quiet_q < 3'h6 || bus_quiet_q < 3'h6)
      else $error("interrupt without cause");
   irq_drop_a: assert property ($fell(irq_o) |-> bus_quiet_q < 3'h6)
      else $error("interrupt dropped without access");
   start_quiet_a: assert property (start_s |=> sda_oe_n_o [*4])
      else $error("driven during address");
   stop_quiet_a: assert property (stop_s |=> sda_oe_n_o throughout (scl_i [*3]))
      else $error("driven after stop");
endmodule
bind srs_status_regs srs_status_regs_monitor i_srs_status_regs_monitor (
   .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .rx_status_i(rx_status_i), .burst_i(burst_i), .irq_o(irq_o)
);

//--- srs_host_model.sv
// Behavioural host controller on the control port
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_host_model (
   // Clock and resolved data line
   input wire logic clk_i,
   input wire logic sda_i,
   // Driven lines, high means released
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Four clocks a phase, twice the device minimum; sample late in high
   task automatic bit_io(input logic b, output logic r);
      scl_o <= 1'b0;
      tick(2);
      sda_o <= b;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      r = sda_i;
   endtask
   // Start when stop is 0, stop when 1: data edge while clock high
   task automatic cond(input logic stop);
      scl_o <= 1'b0;
      tick(2);
      sda_o <= ~stop;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_o <= stop;
      tick(4);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic ao);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(ai, ao);
   endtask
   // One register access; a read uses a repeated start and ends with a nack
   task automatic acc(input logic rd, input logic [7:0] p, input logic [7:0] dw,
                      output logic [7:0] dr, output logic nak);
      logic [7:0] r;
      logic [2:0] a;
      logic x;
      cond(1'b0);
      xfer({`SRS_DEV_ADDR, 1'b0}, 1'b1, r, a[0]);
      xfer(p, 1'b1, r, a[1]);
      if (rd) begin
         cond(1'b0);
         xfer({`SRS_DEV_ADDR, 1'b1}, 1'b1, r, a[2]);
         xfer(8'hff, 1'b1, dr, x);
      end else begin
         xfer(dw, 1'b1, r, a[2]);
      end
      cond(1'b1);
      nak = |a;
   endtask
   task automatic probe(input logic [6:0] ad, output logic nak);
      logic [7:0] r;
      cond(1'b0);
      xfer({ad, 1'b0}, 1'b1, r, nak);
      cond(1'b1);
   endtask
endmodule

//--- srs_status_regs_tb.sv
// Self-checking bench for the receiver status register bank
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_status_regs_tb;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic scl;
   logic host_sda;
   logic sda_w;
   logic sda_o;
   logic sda_oe_n_o;
   logic irq_o;
   logic nak;
   logic [7:0] data;
   srs_pkg::srs_rx_status_t rx = '0;
   srs_pkg::srs_burst_t burst = '0;
   logic [`SRS_RATIO_W-1:0] ratio = '0;
   int n_fail = 0;
   int checks = 0;
   // Pull-up wire: low while either party pulls
   assign sda_w = host_sda & (sda_oe_n_o | sda_o);
   always #12.5 clk_i = ~clk_i;
   srs_status_regs i_srs_status_regs (
      .clk_i(clk_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o), .rx_status_i(rx), .burst_i(burst),
      .rate_ratio_value_i(ratio), .irq_o(irq_o)
   );
   srs_host_model i_srs_host_model (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(host_sda));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic rd(input string what, input logic [6:0] p, input logic [7:0] exp);
      i_srs_host_model.acc(1'b1, {1'b0, p}, 8'h00, data, nak);
      check({what, " ack"}, nak, 1'b0);
      check(what, data, exp);
   endtask
   task automatic wr(input logic [6:0] p, input logic [7:0] d);
      i_srs_host_model.acc(1'b0, {1'b0, p}, d, data, nak);
      check("write ack", nak, 1'b0);
   endtask
   task automatic t_ratio();
      ratio <= 15'h7abc;
      cyc(2);
      check("sda out", sda_o, 1'b0);
      rd("ratio hi", `SRS_REG_RATIO_HI, 8'h7a);
      rd("ratio lo", `SRS_REG_RATIO_LO, 8'hbc);
      wr(`SRS_REG_RATIO_LO, 8'h55);
      rd("ratio kept", `SRS_REG_RATIO_LO, 8'hbc);
      rd("unmapped", 7'h1f, 8'h00);
      i_srs_host_model.probe(`SRS_DEV_ADDR ^ 7'h01, nak);
      check("foreign addr", nak, 1'b1);
   endtask
   task automatic pre_chk(input string what, input logic [31:0] w);
      for (int i = 0; i < 4; i++) begin
         rd(what, `SRS_REG_PRE_C_HI + 7'(i), w[31-8*i -: 8]);
      end
   endtask
   task automatic strobe(input logic mode);
      burst.subframe_mode <= mode;
      burst.strobe <= 1'b1;
      cyc(1);
      burst.strobe <= 1'b0;
      cyc(2);
   endtask
   // Zero outside burst mode, captured inside, channel B in subframe mode
   task automatic t_preamble();
      burst.pc <= 16'h1234;
      burst.pd <= 16'h5678;
      burst.pc_b <= 16'h9abc;
      strobe(1'b0);
      pre_chk("pre idle", 32'h0);
      rx.burst_nonaudio <= 1'b1;
      cyc(3);
      strobe(1'b0);
      pre_chk("pre cd", 32'h12345678);
      strobe(1'b1);
      pre_chk("pre cb", 32'h12349abc);
      rx.burst_nonaudio <= 1'b0;
      cyc(3);
      rd("pre gone", `SRS_REG_PRE_C_HI, 8'h00);
   endtask
   task automatic pulse(input int b);
      rx[b] <= 1'b1;
      cyc(1);
      rx[b] <= 1'b0;
      cyc(1);
   endtask
   // A pulse late in a read must survive the clear at its end
   task automatic t_flags();
      rx <= srs_pkg::srs_rx_status_t'(8'he5);
      cyc(3);
      rd("levels on", `SRS_REG_FAULT, 8'he5);
      rx <= srs_pkg::srs_rx_status_t'(8'h10);
      cyc(3);
      rd("levels off", `SRS_REG_FAULT, 8'h10);
      pulse(3);
      rd("crc set", `SRS_REG_FAULT, 8'h18);
      rd("crc clear", `SRS_REG_FAULT, 8'h10);
      pulse(1);
      cyc(20);
      rd("coding held", `SRS_REG_FAULT, 8'h12);
      fork
         rd("coding clear", `SRS_REG_FAULT, 8'h10);
         begin
            cyc(260);
            pulse(1);
         end
      join
      rd("coding kept", `SRS_REG_FAULT, 8'h12);
      rd("coding gone", `SRS_REG_FAULT, 8'h10);
   endtask
   // Mask gates the interrupt; a read ends it until the next change
   task automatic t_irq();
      check("irq masked", irq_o, 1'b0);
      wr(`SRS_REG_MASK, 8'h01);
      rd("mask", `SRS_REG_MASK, 8'h01);
      rx.emphasis <= 1'b1;
      cyc(4);
      check("irq other", irq_o, 1'b0);
      rx.pll_lock <= 1'b1;
      cyc(4);
      check("irq lock", irq_o, 1'b1);
      rd("lock read", `SRS_REG_FAULT, 8'h51);
      check("irq read", irq_o, 1'b0);
      rd("lock steady", `SRS_REG_FAULT, 8'h51);
      check("irq steady", irq_o, 1'b0);
      rx.pll_lock <= 1'b0;
      cyc(4);
      check("irq lost", irq_o, 1'b1);
      wr(`SRS_REG_MASK, 8'h00);
      cyc(2);
      check("irq off", irq_o, 1'b0);
   endtask
   // Nonaudio stays quiet after a read until a new burst type arrives
   task automatic t_retrig();
      rx.nonaudio <= 1'b1;
      wr(`SRS_REG_MASK, 8'h20);
      rd("nonaudio read", `SRS_REG_FAULT, 8'h70);
      check("irq nonaudio", irq_o, 1'b0);
      burst.pc <= 16'h4321;
      strobe(1'b0);
      check("irq type", irq_o, 1'b1);
      rd("pre new", `SRS_REG_PRE_C_HI, 8'h43);
      rd("type read", `SRS_REG_FAULT, 8'h70);
      check("irq type read", irq_o, 1'b0);
      wr(`SRS_REG_MASK, 8'h00);
   endtask
   initial begin
      cyc(2);
      reset_i <= 1'b0;
      cyc(2);
      rd("mask reset", `SRS_REG_MASK, `SRS_MASK_RESET);
      rd("fault reset", `SRS_REG_FAULT, 8'h00);
      t_ratio();
      t_preamble();
      t_flags();
      t_irq();
      t_retrig();
      give_verdict();
   end
   // Watchdog far beyond the roughly 12000 cycles the sequence needs
   initial begin
      cyc(60000);
      n_fail++;
      give_verdict();
   end
endmodule
